// ---- hw/dcie_top.sv ----
// dcie_top.sv: dual channel input evaluator, one channel pair.
// assumes synchronous inputs, a 100 MHz ref_clk and a plain register port.
// Operation
// RQ1 - equivalent: differ starts; non-equivalent: equal starts
// RQ2 - hold-last substitution keeps pre-discrepancy value
// RQ3 - zero substitution presents zero immediately
// RQ4 - discrepancy time configurable per pair
// RQ5 - running timer returns last value or zero
// RQ6 - cleared early discrepancy abandons timer silently
// RQ7 - expiry flags error naming faulty channels
// RQ8 - zero test needs both channels zero
// RQ9 - non-equivalent zero test needs low channel zero
// RQ10 - no zero test clears when condition ends
// RQ11 - channel passes only when activated; paired mode gates both image bits by act_r[0] only
// RQ12 - configurer assigns internal supply before short test
// RQ13 - pulses shorter than input delay suppressed
// RQ14 - input delay limited by test off/startup
// RQ15 - pulses stretched to extension length minimum
// RQ16 - only zero pulses are stretched
// RQ17 - paired mode extends combined result
// RQ18 - single-channel chatter window per input
// RQ19 - chatter error at configured change count
// RQ20 - expired quiet window waits for next change
// RQ21 - diagnostic clears after three quiet windows
// RQ22 - window 1..100 s, zero means half second
// RQ23 - millisecond tick; reset clears timers, errors
`timescale 1ns/1ps
`default_nettype none
`include "dcie_regs.svh"

module dcie_top
  import dcie_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // field inputs, channel 0 is the low order channel
  input  wire logic [1:0]  sensor_in,
  // process input image and diagnostics
  output logic      [1:0]  process_input_image,
  output logic             disc_error,
  output logic      [1:0]  disc_fault_chan,
  output logic      [1:0]  chatter_diag
);

  // configuration registers
  logic [31:0] ctrl_r,  ctrl_nxt;  // mode bits
  logic [1:0]  act_r,   act_nxt;   // channel activation
  logic [7:0]  dly_r,   dly_nxt;   // input delay, ms
  logic [7:0]  ext_r,   ext_nxt;   // pulse extension, ms
  logic [15:0] disc_r,  disc_nxt;  // discrepancy time, ms
  logic [6:0]  win_r,   win_nxt;   // chatter window, s
  logic [7:0]  chg_r,   chg_nxt;   // chatter change count
  logic [15:0] sup_r,   sup_nxt;   // supply test off / startup, ms
  logic [31:0] rdata_nxt;          // read data next value

  // ms tick divider
  logic [16:0] div_r, div_nxt;
  logic        tick_r, tick_nxt;

  // delay filter per channel
  logic [1:0]  filt_r,   filt_nxt;   // filtered level
  logic [7:0]  fcnt_r [2];           // ms the input differs from filtered level
  logic [7:0]  fcnt_nxt [2];

  // discrepancy
  dcie_disc_t  dst_r, dst_nxt;
  logic [15:0] dcnt_r, dcnt_nxt;
  logic        last_r, last_nxt;     // last valid pair value
  logic [1:0]  fault_r, fault_nxt;
  logic        zseen_r, zseen_nxt;   // low channel returned to zero

  // extension and image
  logic [1:0]  ext_lvl_r, ext_lvl_nxt;
  logic [7:0]  ecnt_r [2];
  logic [7:0]  ecnt_nxt [2];
  logic [1:0]  img_r, img_nxt;

  // chatter per channel
  logic [1:0]  cact_r, cact_nxt;     // window running
  logic [16:0] cwin_r [2];           // ms left in window
  logic [16:0] cwin_nxt [2];
  logic [7:0]  cchg_r [2];
  logic [7:0]  cchg_nxt [2];
  logic [1:0]  cquiet_r [2];         // quiet windows since error
  logic [1:0]  cquiet_nxt [2];
  logic [1:0]  cdiag_r, cdiag_nxt;
  logic [1:0]  cprev_r, cprev_nxt;

  // derived values
  logic [7:0]  dly_min;              // least allowed delay
  logic [7:0]  dly_eff;              // delay in use
  logic [16:0] win_ms;               // window length in ms
  logic        mismatch;             // pair disagrees for its mode
  logic        pair_val;             // combined pair value
  logic [1:0]  eval_val;             // values before extension

  // register write and read decode
  always_comb begin
    ctrl_nxt  = ctrl_r;
    act_nxt   = act_r;
    dly_nxt   = dly_r;
    ext_nxt   = ext_r;
    disc_nxt  = disc_r;
    win_nxt   = win_r;
    chg_nxt   = chg_r;
    sup_nxt   = sup_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `DCIE_CTRL_OFS: ctrl_nxt = {27'h0, reg_wdata[4:0]};
        `DCIE_ACT_OFS:  act_nxt  = reg_wdata[1:0];
        `DCIE_DLY_OFS:  dly_nxt  = reg_wdata[7:0];
        `DCIE_EXT_OFS:  ext_nxt  = reg_wdata[7:0];
        `DCIE_DISC_OFS: disc_nxt = reg_wdata[15:0]; // RQ4
        `DCIE_CHAT_OFS: begin
          win_nxt = (reg_wdata[6:0] > 7'd100) ? 7'd100 : reg_wdata[6:0]; // RQ22
          chg_nxt = reg_wdata[15:8];
        end
        `DCIE_SUP_OFS:  sup_nxt  = reg_wdata[15:0];
        default: ;  // unmapped writes are ignored
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `DCIE_CTRL_OFS: rdata_nxt = ctrl_r;
        `DCIE_ACT_OFS:  rdata_nxt = {30'h0, act_r};
        `DCIE_DLY_OFS:  rdata_nxt = {24'h0, dly_eff};
        `DCIE_EXT_OFS:  rdata_nxt = {24'h0, ext_r};
        `DCIE_DISC_OFS: rdata_nxt = {16'h0, disc_r};
        `DCIE_CHAT_OFS: rdata_nxt = {16'h0, chg_r, 1'b0, win_r};
        `DCIE_SUP_OFS:  rdata_nxt = {16'h0, sup_r};
        `DCIE_STAT_OFS: rdata_nxt = {26'h0, cdiag_r, fault_r,
                                     (dst_r == DCIE_ERR), (dst_r == DCIE_RUN)};
        `DCIE_IMG_OFS:  rdata_nxt = {28'h0, filt_r, img_r};
        default:        rdata_nxt = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // delay floor from supply test timing when short test is on
  always_comb begin
    dly_min = 8'h00;
    if (ctrl_r[`DCIE_CTRL_SCT]) begin
      dly_min = sup_r[`DCIE_SUP_OFF_LSB +: 8] + sup_r[`DCIE_SUP_RUN_LSB +: 8]; // RQ14
    end
    dly_eff = (dly_r < dly_min) ? dly_min : dly_r; // RQ14
    win_ms  = (win_r == 7'h00) ? 17'(`DCIE_HALF_WIN_MS)
                               : 17'(win_r * `DCIE_SEC_MS); // RQ22
  end

  // millisecond tick
  always_comb begin
    div_nxt  = div_r + 17'h00001;
    tick_nxt = 1'b0;
    if (div_r == 17'(`DCIE_TICK_CYC - 1)) begin
      div_nxt  = 17'h00000;
      tick_nxt = 1'b1; // RQ23
    end
  end

  // input delay filter: level accepted only after steady for dly_eff ms
  always_comb begin
    filt_nxt = filt_r;
    for (int i = 0; i < 2; i++) begin
      fcnt_nxt[i] = fcnt_r[i];
      if (sensor_in[i] == filt_r[i]) begin
        fcnt_nxt[i] = 8'h00; // RQ13
      end else if (fcnt_r[i] >= dly_eff) begin
        filt_nxt[i] = sensor_in[i];
        fcnt_nxt[i] = 8'h00;
      end else if (tick_r) begin
        fcnt_nxt[i] = fcnt_r[i] + 8'h01; // RQ13
      end
    end
  end

  // discrepancy analysis on the filtered pair
  always_comb begin
    mismatch = ctrl_r[`DCIE_CTRL_NONEQ] ? (filt_r[0] == filt_r[1])
                                        : (filt_r[0] != filt_r[1]); // RQ1
    dst_nxt   = dst_r;
    dcnt_nxt  = dcnt_r;
    last_nxt  = last_r;
    fault_nxt = fault_r;
    zseen_nxt = zseen_r;
    case (dst_r)
      DCIE_IDLE: begin
        if (mismatch) begin
          dst_nxt  = DCIE_RUN; // RQ1
          dcnt_nxt = 16'h0000;
        end else begin
          last_nxt = filt_r[0]; // RQ2
        end
      end
      DCIE_RUN: begin
        if (!mismatch) begin
          dst_nxt = DCIE_IDLE; // RQ6
        end else if (dcnt_r >= disc_r) begin
          dst_nxt   = DCIE_ERR; // RQ7
          fault_nxt = 2'b11;    // RQ7
          zseen_nxt = 1'b0;
        end else if (tick_r) begin
          dcnt_nxt = dcnt_r + 16'h0001;
        end
      end
      DCIE_ERR: begin
        if (!filt_r[0]) begin
          zseen_nxt = 1'b1;
        end
        if (ctrl_r[`DCIE_CTRL_ZTEST]) begin
          if (ctrl_r[`DCIE_CTRL_NONEQ]) begin
            if ((zseen_r || !filt_r[0]) && !mismatch) begin
              dst_nxt   = DCIE_IDLE; // RQ9
              fault_nxt = 2'b00;
            end
          end else if (filt_r == 2'b00) begin
            dst_nxt   = DCIE_IDLE; // RQ8
            fault_nxt = 2'b00;
          end
        end else if (!mismatch) begin
          dst_nxt   = DCIE_IDLE; // RQ10
          fault_nxt = 2'b00;
        end
      end
      default: begin
        dst_nxt   = DCIE_IDLE;
        fault_nxt = 2'b00;
      end
    endcase
  end

  // value presented before extension
  always_comb begin
    if (dst_r == DCIE_ERR) begin
      pair_val = 1'b0;
    end else if (dst_r == DCIE_RUN || mismatch) begin
      pair_val = ctrl_r[`DCIE_CTRL_ZSUB] ? 1'b0 : last_r; // RQ3 RQ5 RQ2
    end else begin
      pair_val = filt_r[0];
    end
    if (ctrl_r[`DCIE_CTRL_PAIRED]) begin
      eval_val = {2{pair_val & act_r[0]}}; // RQ17 RQ11
    end else begin
      eval_val = filt_r & act_r; // RQ11
    end
  end

  // zero pulse extension and process input image
  always_comb begin
    ext_lvl_nxt = ext_lvl_r;
    img_nxt     = img_r;
    for (int i = 0; i < 2; i++) begin
      ecnt_nxt[i] = ecnt_r[i];
      if (!eval_val[i]) begin
        img_nxt[i]  = 1'b0;
        ecnt_nxt[i] = 8'h00; // RQ16
        if (ext_lvl_r[i]) begin
          ext_lvl_nxt[i] = 1'b0;
        end else if (tick_r && ecnt_r[i] != 8'hff) begin
          ecnt_nxt[i] = ecnt_r[i] + 8'h01;
        end
      end else begin
        ext_lvl_nxt[i] = 1'b1;
        if (img_r[i] || ecnt_r[i] >= ext_r) begin
          img_nxt[i] = 1'b1; // RQ15
        end else if (tick_r) begin
          ecnt_nxt[i] = ecnt_r[i] + 8'h01; // RQ15
        end
      end
    end
  end

  // chatter monitoring per channel, single-channel evaluation only
  always_comb begin
    cact_nxt  = cact_r;
    cdiag_nxt = cdiag_r;
    cprev_nxt = filt_r;
    for (int i = 0; i < 2; i++) begin
      cwin_nxt[i]   = cwin_r[i];
      cchg_nxt[i]   = cchg_r[i];
      cquiet_nxt[i] = cquiet_r[i];
      if (ctrl_r[`DCIE_CTRL_PAIRED]) begin
        cact_nxt[i] = 1'b0; // RQ18
      end else if (!cact_r[i]) begin
        if (filt_r[i] != cprev_r[i]) begin
          cact_nxt[i] = 1'b1; // RQ18 RQ20
          cwin_nxt[i] = win_ms;
          cchg_nxt[i] = 8'h01;
        end
      end else if (cwin_r[i] == 17'h00000) begin
        cact_nxt[i] = 1'b0; // RQ20
        if (cdiag_r[i]) begin
          if (cquiet_r[i] == 2'(`DCIE_QUIET_WINDOWS - 1)) begin
            cdiag_nxt[i] = 1'b0; // RQ21
          end
          cquiet_nxt[i] = cquiet_r[i] + 2'h1;
        end
      end else begin
        if (filt_r[i] != cprev_r[i]) begin
          cchg_nxt[i] = cchg_r[i] + 8'h01;
        end
        if (cchg_nxt[i] >= chg_r && chg_r != 8'h00) begin
          cdiag_nxt[i]  = 1'b1; // RQ19
          cquiet_nxt[i] = 2'h0; // RQ21
          cwin_nxt[i]   = win_ms;
          cchg_nxt[i]   = 8'h00;
        end else if (tick_r) begin
          cwin_nxt[i] = cwin_r[i] - 17'h00001;
        end
      end
    end
  end

  // state registers, set to their reset values by synchronous reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r    <= `DCIE_CTRL_RST;
      act_r     <= 2'(`DCIE_ACT_RST);
      dly_r     <= 8'(`DCIE_DLY_RST);
      ext_r     <= 8'(`DCIE_EXT_RST);
      disc_r    <= 16'(`DCIE_DISC_RST);
      win_r     <= 7'(`DCIE_CHAT_RST);
      chg_r     <= 8'(`DCIE_CHAT_RST >> 8);
      sup_r     <= 16'(`DCIE_SUP_RST);
      reg_rdata <= 32'h0000_0000;
      div_r     <= 17'h00000;
      tick_r    <= 1'b0;
      filt_r    <= 2'b00;
      dst_r     <= DCIE_IDLE; // RQ23
      dcnt_r    <= 16'h0000;
      last_r    <= 1'b0;
      fault_r   <= 2'b00;
      zseen_r   <= 1'b0;
      ext_lvl_r <= 2'b00;
      img_r     <= 2'b00;
      cact_r    <= 2'b00;
      cdiag_r   <= 2'b00;
      cprev_r   <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        fcnt_r[i]   <= 8'h00;
        ecnt_r[i]   <= 8'h00;
        cwin_r[i]   <= 17'h00000;
        cchg_r[i]   <= 8'h00;
        cquiet_r[i] <= 2'h0;
      end
    end else begin
      ctrl_r    <= ctrl_nxt;
      act_r     <= act_nxt;
      dly_r     <= dly_nxt;
      ext_r     <= ext_nxt;
      disc_r    <= disc_nxt;
      win_r     <= win_nxt;
      chg_r     <= chg_nxt;
      sup_r     <= sup_nxt;
      reg_rdata <= rdata_nxt;
      div_r     <= div_nxt;
      tick_r    <= tick_nxt;
      filt_r    <= filt_nxt;
      dst_r     <= dst_nxt;
      dcnt_r    <= dcnt_nxt;
      last_r    <= last_nxt;
      fault_r   <= fault_nxt;
      zseen_r   <= zseen_nxt;
      ext_lvl_r <= ext_lvl_nxt;
      img_r     <= img_nxt;
      cact_r    <= cact_nxt;
      cdiag_r   <= cdiag_nxt;
      cprev_r   <= cprev_nxt;
      for (int i = 0; i < 2; i++) begin
        fcnt_r[i]   <= fcnt_nxt[i];
        ecnt_r[i]   <= ecnt_nxt[i];
        cwin_r[i]   <= cwin_nxt[i];
        cchg_r[i]   <= cchg_nxt[i];
        cquiet_r[i] <= cquiet_nxt[i];
      end
    end
  end

  // outputs taken straight from flip-flops
  assign process_input_image = img_r;
  assign disc_fault_chan     = fault_r;
  assign chatter_diag        = cdiag_r;

  // error flag registered alongside the state
  logic err_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      err_r <= 1'b0;
    end else begin
      err_r <= (dst_nxt == DCIE_ERR); // RQ7
    end
  end
  assign disc_error = err_r;

endmodule

`default_nettype wire

// ---- hw/dcie_regs.svh ----
// dcie_regs.svh: register offsets, field positions, reset values and timing
// counts for the dual channel input evaluator.
// assumes a 100 MHz reference clock and a word-wide plain register port.
`ifndef DCIE_REGS_SVH
`define DCIE_REGS_SVH

// timing
`define DCIE_CLK_MHZ        100
`define DCIE_TICK_US        1000
`define DCIE_TICK_CYC       (`DCIE_CLK_MHZ * `DCIE_TICK_US)
`define DCIE_HALF_WIN_MS    500
`define DCIE_SEC_MS         1000
`define DCIE_QUIET_WINDOWS  3

// register offsets (byte addresses)
`define DCIE_CTRL_OFS       8'h00
`define DCIE_ACT_OFS        8'h04
`define DCIE_DLY_OFS        8'h08
`define DCIE_EXT_OFS        8'h0c
`define DCIE_DISC_OFS       8'h10
`define DCIE_CHAT_OFS       8'h14
`define DCIE_SUP_OFS        8'h18
`define DCIE_STAT_OFS       8'h1c
`define DCIE_IMG_OFS        8'h20

// control fields
`define DCIE_CTRL_NONEQ     0
`define DCIE_CTRL_ZSUB      1
`define DCIE_CTRL_ZTEST     2
`define DCIE_CTRL_PAIRED    3
`define DCIE_CTRL_SCT       4

// supply register fields: off time in [7:0], startup time in [15:8]
`define DCIE_SUP_OFF_LSB    0
`define DCIE_SUP_RUN_LSB    8

// reset values
`define DCIE_CTRL_RST       32'h0000_0008
`define DCIE_ACT_RST        32'h0000_0003
`define DCIE_DLY_RST        32'h0000_0003
`define DCIE_EXT_RST        32'h0000_0000
`define DCIE_DISC_RST       32'h0000_0064
`define DCIE_CHAT_RST       32'h0000_0801
`define DCIE_SUP_RST        32'h0000_0000

`endif

// ---- hw/dcie_pkg.sv ----
// dcie_pkg.sv: types shared by the dual channel input evaluator.
// assumes the constants header is included by the design file.
package dcie_pkg;
  // discrepancy state, gray coded along idle -> run -> error
  typedef enum logic [1:0] {
    DCIE_IDLE = 2'b00,
    DCIE_RUN  = 2'b01,
    DCIE_ERR  = 2'b11
  } dcie_disc_t;
endpackage

// ---- testbench/dcie_top_properties.sv ----
// dcie_top_properties.sv: port-level checks of the input evaluator.
// assumes the register map and reset values of dcie_regs.svh.
`timescale 1ns/1ps
`default_nettype none
`include "dcie_regs.svh"

module dcie_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // results
  input wire logic [1:0]  process_input_image,
  input wire logic        disc_error,
  input wire logic [1:0]  disc_fault_chan,
  input wire logic [1:0]  chatter_diag
);
  logic [31:0] ctrl_r, ctrl_nxt;  // shadow of the control word
  logic [31:0] act_r, act_nxt;    // shadow of the activation word
  logic [31:0] disc_r, disc_nxt;  // shadow of the discrepancy time

  // follow configuration writes seen on the port
  always_comb begin
    ctrl_nxt = ctrl_r;
    act_nxt = act_r;
    disc_nxt = disc_r;
    if (reg_wr && reg_addr == `DCIE_CTRL_OFS) ctrl_nxt = reg_wdata;
    if (reg_wr && reg_addr == `DCIE_ACT_OFS) act_nxt = reg_wdata;
    if (reg_wr && reg_addr == `DCIE_DISC_OFS) disc_nxt = reg_wdata;
  end

  // register the shadows, reset to the documented values
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= `DCIE_CTRL_RST;
      act_r <= `DCIE_ACT_RST;
      disc_r <= `DCIE_DISC_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      act_r <= act_nxt;
      disc_r <= disc_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // a read strobe at a given offset
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // discrepancy time written, then read back at once
  sequence s_disc_wr;
    reg_wr && reg_addr == `DCIE_DISC_OFS ##1 s_rd(`DCIE_DISC_OFS);
  endsequence

  AST_DISC_RB: assert property (
    s_disc_wr |=> reg_rdata[15:0] == disc_r[15:0])
    else $error("discrepancy time readback wrong");
  AST_STAT: assert property (
    s_rd(`DCIE_STAT_OFS) |=> reg_rdata[5:1] ==
      $past({chatter_diag, disc_fault_chan, disc_error}))
    else $error("status word disagrees with outputs");
  AST_IMG: assert property (
    s_rd(`DCIE_IMG_OFS) |=> reg_rdata[1:0] == $past(process_input_image))
    else $error("image word disagrees with output");
  AST_RST: assert property (
    $fell(sys_rst) |-> process_input_image == 2'h0 && !disc_error &&
      disc_fault_chan == 2'h0 && chatter_diag == 2'h0)
    else $error("outputs not clear after reset");
  AST_FAULT: assert property (
    disc_error |-> disc_fault_chan == 2'h3)
    else $error("fault channels not named on error");
  AST_ERR_ZERO: assert property (
    $rose(disc_error) |-> ##[0:2] process_input_image == 2'h0)
    else $error("image not zero on discrepancy error");
  AST_PAIR: assert property (
    ctrl_r[`DCIE_CTRL_PAIRED] [*4] |->
      process_input_image[0] == process_input_image[1])
    else $error("paired image bits differ");
  AST_ACT: assert property (
    (act_r[1:0] == 2'h0) [*4] |-> process_input_image == 2'h0)
    else $error("inactive channel reaches image");
  AST_CHAT_OFF: assert property (
    ctrl_r[`DCIE_CTRL_PAIRED] && chatter_diag == 2'h0 |=>
      chatter_diag == 2'h0)
    else $error("chatter raised in paired mode");
endmodule

bind dcie_top dcie_props dcie_props_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .process_input_image(process_input_image),
  .disc_error(disc_error), .disc_fault_chan(disc_fault_chan),
  .chatter_diag(chatter_diag));
`default_nettype wire

// ---- testbench/dcie_sensor_model.sv ----
// dcie_sensor_model.sv: two-channel contact sensor on the field inputs.
// assumes the bench sets the wanted contact state just after an edge.
`timescale 1ns/1ps
`default_nettype none

module dcie_sensor_model (
  // clock
  input wire logic  ref_clk,
  // wanted contact state per channel
  input wire logic  [1:0] contact,
  // field lines
  output var logic  [1:0] sensor_in
);
  logic lag_r;  // channel 1 contact, one clock late

  // channel 1 closes a clock after channel 0, like real contacts
  initial begin
    lag_r = 1'b0;
    sensor_in = 2'h0;
  end
  always @(posedge ref_clk) begin
    lag_r <= contact[1];
    sensor_in <= {lag_r, contact[0]};
  end
endmodule
`default_nettype wire

// ---- testbench/dcie_top_tb.sv ----
// dcie_top_tb.sv: self-checking bench of the dual channel input evaluator.
// assumes the 1 ms tick of the header; the whole run ends before the first tick.
`timescale 1ns/1ps
`default_nettype none
`include "dcie_regs.svh"

module dcie_top_tb;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, disc_error;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0]  contact, sensor_in, process_input_image;
  logic [1:0]  disc_fault_chan, chatter_diag;
  int          mismatches, checks;

  // 100 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  dcie_top dcie_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sensor_in(sensor_in),
    .process_input_image(process_input_image), .disc_error(disc_error),
    .disc_fault_chan(disc_fault_chan), .chatter_diag(chatter_diag));
  dcie_sensor_model dcie_sensor_model_i (.ref_clk(ref_clk),
    .contact(contact), .sensor_in(sensor_in));

  // compare one value, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write; a second write waits a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    if (reg_wr === 1'b1) @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read, data judged in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge ref_clk);
  endtask

  // wait for image (or error flag) to reach a value, bounded
  task automatic wait_out(input bit err, input logic [1:0] e, input int lim);
    logic [1:0] v;
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      v = err ? {1'b0, disc_error} : process_input_image;
      n++;
    end while (v !== e && n < lim);
    chk({30'h0, v}, {30'h0, e});
    @(posedge ref_clk);
  endtask

  // image and error flag must stay put for a span
  task automatic hold_chk(input logic [1:0] e, input int cyc);
    int n;
    n = 0;
    repeat (cyc) begin
      @(negedge ref_clk);
      if (process_input_image !== e || disc_error !== 1'b0) n++;
    end
    chk(n, 0);
    @(posedge ref_clk);
  endtask

  // outputs and configuration after reset
  task automatic t_reset();
    #1 chk({25'h0, process_input_image, disc_error, disc_fault_chan,
            chatter_diag}, 32'h0);
    @(posedge ref_clk);
    rd_chk(`DCIE_CTRL_OFS, `DCIE_CTRL_RST);
    rd_chk(`DCIE_ACT_OFS, `DCIE_ACT_RST);
    rd_chk(`DCIE_DLY_OFS, `DCIE_DLY_RST);
    rd_chk(`DCIE_EXT_OFS, `DCIE_EXT_RST);
    rd_chk(`DCIE_DISC_OFS, `DCIE_DISC_RST);
    rd_chk(`DCIE_CHAT_OFS, `DCIE_CHAT_RST);
    rd_chk(`DCIE_STAT_OFS, 32'h0);
  endtask

  // back-to-back access, unmapped place, read data for one cycle only
  task automatic t_regs();
    wr(`DCIE_DISC_OFS, 32'h0000_0123);
    rd_chk(`DCIE_DISC_OFS, 32'h0000_0123);
    #1 chk(reg_rdata, 32'h0);
    @(posedge ref_clk);
    wr(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0);
    // supply timing assigned before the short test is switched on
    wr(`DCIE_SUP_OFS, 32'h0000_0203);
    wr(`DCIE_CTRL_OFS, 32'h0000_0018);
    rd_chk(`DCIE_DLY_OFS, 32'h0000_0005);
    wr(`DCIE_CTRL_OFS, 32'h0000_0008);
  endtask

  // paired pass-through and channel activation
  task automatic t_pass();
    wr(`DCIE_DLY_OFS, 32'h0);
    wr(`DCIE_DISC_OFS, 32'h5);
    contact <= 2'h3;
    wait_out(0, 2'h3, 20);
    wr(`DCIE_ACT_OFS, 32'h0);
    wait_out(0, 2'h0, 4);
    wr(`DCIE_ACT_OFS, 32'h3);
    wait_out(0, 2'h3, 4);
  endtask

  // hold-last while the timer runs, then silent recovery
  task automatic t_hold();
    contact <= 2'h1;
    hold_chk(2'h3, 50);
    rd_chk(`DCIE_STAT_OFS, 32'h1);
    contact <= 2'h3;
    hold_chk(2'h3, 50);
    rd_chk(`DCIE_STAT_OFS, 32'h0);
  endtask

  // zero substitution, then early recovery
  task automatic t_subst();
    wr(`DCIE_CTRL_OFS, 32'h0000_000a);
    contact <= 2'h1;
    wait_out(0, 2'h0, 20);
    chk({31'h0, disc_error}, 32'h0);
    contact <= 2'h3;
    wait_out(0, 2'h3, 20);
    chk({31'h0, disc_error}, 32'h0);
  endtask

  // expiry raises the error; without zero test it clears on agreement
  task automatic t_err();
    // zero discrepancy time expires at once, no tick needed
    wr(`DCIE_DISC_OFS, 32'h0);
    contact <= 2'h1;
    wait_out(1, 2'h1, 20);
    chk({30'h0, disc_fault_chan}, 32'h3);
    contact <= 2'h3;
    wait_out(1, 2'h0, 20);
    // zero test: agreement on ones is not enough
    wr(`DCIE_CTRL_OFS, 32'h0000_000e);
    contact <= 2'h1;
    wait_out(1, 2'h1, 20);
    contact <= 2'h3;
    repeat (10) @(posedge ref_clk);
    #1 chk({31'h0, disc_error}, 32'h1);
    contact <= 2'h0;
    wait_out(1, 2'h0, 20);
    // non-equivalent: equal levels are the fault
    wr(`DCIE_CTRL_OFS, 32'h0000_000f);
    wait_out(1, 2'h1, 20);
    contact <= 2'h2;
    wait_out(1, 2'h0, 20);
  endtask

  // single-channel chatter: eighth change raises the diagnostic
  task automatic t_chat();
    wr(`DCIE_DISC_OFS, 32'h0000_ffff);
    wr(`DCIE_CTRL_OFS, 32'h0);
    repeat (7) begin
      contact <= contact ^ 2'h1;
      repeat (4) @(posedge ref_clk);
    end
    #1 chk({30'h0, chatter_diag}, 32'h0);
    contact <= contact ^ 2'h1;
    repeat (4) @(posedge ref_clk);
    #1 chk({30'h0, chatter_diag}, 32'h1);
  endtask

  // counts, verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
    contact = 2'h0;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_pass();
    t_hold();
    t_subst();
    t_err();
    t_chat();
    results();
  end

  // watchdog against a hang, ahead of the first ms tick
  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
